// *** hw/timer_pkg.sv ***
// Package for the 16-bit timer: register offsets, field layouts, reset values.
// Assumes a byte-wide register port with one-cycle read latency.
package timer_pkg;

  // ---------------------------------------------------------------------------
  // Register map (byte offsets on the plain port)
  // ---------------------------------------------------------------------------
  localparam logic [3:0] CTL0_OFS = 4'h0;
  localparam logic [3:0] CTL1_OFS = 4'h1;
  localparam logic [3:0] CNTH_OFS = 4'h2;
  localparam logic [3:0] CNTL_OFS = 4'h3;
  localparam logic [3:0] PWMH_OFS = 4'h4;
  localparam logic [3:0] PWML_OFS = 4'h5;
  localparam logic [3:0] RLDH_OFS = 4'h6;
  localparam logic [3:0] RLDL_OFS = 4'h7;
  localparam logic [3:0] ISTAT_OFS = 4'h8;
  localparam logic [3:0] IMASK_OFS = 4'h9;

  // ---------------------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------------------
  // timer_control_zero: [1:0] interrupt_source_config, [2] pin function enable
  localparam int ISRC_LSB = 0;
  localparam int PINEN_BIT = 2;
  // control one: [7] enable, [6] output_polarity_select, [5:3] prescale, [1:0] mode
  localparam int EN_BIT = 7;
  localparam int POL_BIT = 6;
  localparam int PRE_LSB = 3;
  localparam int MODE_LSB = 0;
  // Status bits
  localparam int EVT_RELOAD = 0;
  localparam int EVT_MATCH = 1;
  localparam int EVT_CAPTURE = 2;

  localparam logic [15:0] COUNT_RESTART = 16'h0001;
  localparam logic [15:0] COUNT_RESET = 16'h0001;
  localparam logic [15:0] PWM_RESET = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'hffff;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] EVT_NONE = 3'h0;

  typedef enum logic [1:0] {MODE_PWM, MODE_CAPTURE, MODE_COMPARE, MODE_IDLE} mode_type;
  // Capture interrupt sources: both, capture only, reload only
  typedef enum logic [1:0] {ISRC_BOTH, ISRC_CAPTURE, ISRC_RELOAD, ISRC_SPARE} isrc_type;

  typedef struct packed {
    logic enable;
    logic polarity;
    logic [2:0] prescale;
    mode_type mode;
    isrc_type isrc;
    logic pinEnable;
  } ctrl_type;

  typedef struct packed {
    logic reload;
    logic match;
    logic capture;
  } evt_type;

endpackage : timer_pkg

// *** hw/timer_prescaler.sv ***
// Prescaler: divides sys_clk by 2**prescale and emits a one-cycle tick.
// Assumes the enable level comes from the same clock domain.
`timescale 1ns/10ps
module timer_prescaler
  import timer_pkg::*;
#(
  parameter int DIV_W = 7
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic enable,
  input wire logic [2:0] prescale,
  output logic tick
);

  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] nxt_div;
  logic [DIV_W-1:0] limit;

  always_comb begin
    limit = DIV_W'((1 << prescale) - 1);
    tick = enable && (div_ff == limit);
    nxt_div = div_ff;
    if (!enable || tick) begin
      nxt_div = '0;
    end else begin
      nxt_div = div_ff + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      div_ff <= '0;
    end else begin
      div_ff <= nxt_div;
    end
  end

endmodule : timer_prescaler

// *** hw/timer_pin_sync.sv ***
// Two-stage synchroniser for the capture input pin plus rising-edge pulse.
// Assumes the pin is asynchronous to sys_clk.
`timescale 1ns/10ps
module timer_pin_sync (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic pinIn,
  output logic rise
);

  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // Only sync_ff feeds the edge detector; meta_ff is never read elsewhere
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= pinIn;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign rise = sync_ff && !last_ff;

endmodule : timer_pin_sync

// *** hw/timer_pwm_capture_compare.sv ***
// 16-bit up-counting timer with PWM, capture and compare modes.
// Assumes a byte register port on sys_clk and an asynchronous capture pin.
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/10ps
// Behaviour
// [RL1] PWM: count up; at match with PWM value, toggle output.
// [RL2] PWM: at reload value, interrupt, restart count at 0001H.
// [RL3] Polarity 1: output starts high, low at match, high at reload.
// [RL4] Polarity 0: output starts low, high at match, low at reload.
// [RL5] Software start count only affects first period; later periods start 0001H.
// [RL6] Software keeps reload strictly greater than PWM value.
// [RL7] Software configures fully before enabling the timer.
// [RL8] Capture: PWM registers written only on capture, not on reload.
// [RL9] Capture interrupt on both events, or one chosen by source field.
// [RL10] Compare: at reload-register value, interrupt and keep counting.
// [RL11] Compare: with pin enabled, invert output at each compare.
// [RL12] Compare: count wraps FFFFH to 0000H.
// [RL13] Counter steps once per prescale tick; holds while disabled.
module timer_pwm_capture_compare
  import timer_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  input wire logic captureIn,
  output logic timerOut,
  output logic timerOutEn,
  output logic irq
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  ctrl_type ctrl_ff, nxt_ctrl;
  logic [15:0] count_ff, nxt_count;
  logic [15:0] pwm_ff, nxt_pwm;
  logic [15:0] reload_ff, nxt_reload;
  logic [2:0] status_ff, nxt_status;
  logic [2:0] mask_ff, nxt_mask;
  logic out_ff, nxt_out;
  logic [7:0] rdata_ff, nxt_rdata;
  logic tick;
  logic capRise;
  logic reloadHit;
  logic matchHit;
  logic capEvt;
  evt_type evt;

  function automatic logic [15:0] set_byte(input logic [15:0] word, input logic high, input logic [7:0] b);
    set_byte = high ? {b, word[7:0]} : {word[15:8], b};
  endfunction : set_byte

  timer_prescaler u_pre (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .enable(ctrl_ff.enable),
    .prescale(ctrl_ff.prescale),
    .tick(tick)
  );

  timer_pin_sync u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pinIn(captureIn),
    .rise(capRise)
  );

  // ---------------------------------------------------------------------------
  // Event decode
  // ---------------------------------------------------------------------------
  always_comb begin
    // Both hits decode independently; reload outranks match only for the PWM output level
    reloadHit = tick && (count_ff == reload_ff);
    matchHit = tick && (count_ff == pwm_ff);
    capEvt = ctrl_ff.enable && (ctrl_ff.mode == MODE_CAPTURE) && capRise;
    evt = '0;
    unique case (ctrl_ff.mode)
      MODE_PWM: begin
        evt.reload = reloadHit; // RL2
        evt.match = matchHit;
      end
      MODE_CAPTURE: begin
        evt.reload = reloadHit && (ctrl_ff.isrc != ISRC_CAPTURE); // RL9
        evt.capture = capEvt && (ctrl_ff.isrc != ISRC_RELOAD); // RL9
      end
      MODE_COMPARE: begin
        evt.reload = reloadHit; // RL10
      end
      MODE_IDLE: begin
        evt = '0;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Counter, capture and output
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_count = count_ff;
    nxt_pwm = pwm_ff;
    nxt_out = out_ff;
    nxt_ctrl = ctrl_ff;
    nxt_reload = reload_ff;
    nxt_mask = mask_ff;
    // Set wins over clear: hardware events OR in after the write-one clear
    nxt_status = status_ff;
    if (tick) begin
      if (ctrl_ff.mode != MODE_COMPARE && count_ff == reload_ff) begin
        nxt_count = COUNT_RESTART; // RL2 RL5
      end else begin
        nxt_count = count_ff + 16'h0001; // RL13 RL12
      end
    end
    unique case (ctrl_ff.mode)
      MODE_PWM: begin
        if (reloadHit) begin
          nxt_out = ctrl_ff.polarity; // RL3 RL4
        end else if (matchHit) begin
          nxt_out = !out_ff; // RL1
        end
      end
      MODE_CAPTURE: begin
        if (capEvt) begin
          nxt_pwm = count_ff; // RL8
        end
      end
      MODE_COMPARE: begin
        if (reloadHit && ctrl_ff.pinEnable) begin
          nxt_out = !out_ff; // RL11
        end
      end
      MODE_IDLE: begin
        nxt_out = out_ff;
      end
    endcase
    // Writes follow the tick updates so software wins, except over status events ORed in below
    if (regWrite) begin
      unique case (regAddr)
        CTL0_OFS: begin
          nxt_ctrl.isrc = isrc_type'(regWdata[ISRC_LSB +: 2]);
          nxt_ctrl.pinEnable = regWdata[PINEN_BIT];
        end
        CTL1_OFS: begin
          nxt_ctrl.enable = regWdata[EN_BIT];
          nxt_ctrl.polarity = regWdata[POL_BIT];
          nxt_ctrl.prescale = regWdata[PRE_LSB +: 3];
          nxt_ctrl.mode = mode_type'(regWdata[MODE_LSB +: 2]);
          // Idle output level follows polarity while disabled
          if (!regWdata[EN_BIT]) begin
            nxt_out = regWdata[POL_BIT];
          end
        end
        CNTH_OFS: nxt_count = set_byte(count_ff, 1'b1, regWdata);
        CNTL_OFS: nxt_count = set_byte(count_ff, 1'b0, regWdata);
        PWMH_OFS: nxt_pwm = set_byte(pwm_ff, 1'b1, regWdata);
        PWML_OFS: nxt_pwm = set_byte(pwm_ff, 1'b0, regWdata);
        RLDH_OFS: nxt_reload = set_byte(reload_ff, 1'b1, regWdata);
        RLDL_OFS: nxt_reload = set_byte(reload_ff, 1'b0, regWdata);
        ISTAT_OFS: nxt_status = status_ff & ~regWdata[2:0];
        IMASK_OFS: nxt_mask = regWdata[2:0];
        default: nxt_mask = mask_ff;
      endcase
    end
    // Status bits set by name; the struct packs reload at its top
    nxt_status[EVT_RELOAD] = nxt_status[EVT_RELOAD] | evt.reload;
    nxt_status[EVT_MATCH] = nxt_status[EVT_MATCH] | evt.match;
    nxt_status[EVT_CAPTURE] = nxt_status[EVT_CAPTURE] | evt.capture;
  end

  // ---------------------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------------------
  always_comb begin
    // Idle cycles return zero so stale data never lingers
    nxt_rdata = BYTE_RESET;
    if (regRead) begin
      unique case (regAddr)
        CTL0_OFS: nxt_rdata = {5'h00, ctrl_ff.pinEnable, ctrl_ff.isrc};
        CTL1_OFS: nxt_rdata = {ctrl_ff.enable, ctrl_ff.polarity, ctrl_ff.prescale, 1'b0, ctrl_ff.mode};
        CNTH_OFS: nxt_rdata = count_ff[15:8];
        CNTL_OFS: nxt_rdata = count_ff[7:0];
        PWMH_OFS: nxt_rdata = pwm_ff[15:8];
        PWML_OFS: nxt_rdata = pwm_ff[7:0];
        RLDH_OFS: nxt_rdata = reload_ff[15:8];
        RLDL_OFS: nxt_rdata = reload_ff[7:0];
        ISTAT_OFS: nxt_rdata = {5'h00, status_ff};
        IMASK_OFS: nxt_rdata = {5'h00, mask_ff};
        default: nxt_rdata = BYTE_RESET;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= '0;
      count_ff <= COUNT_RESET;
      pwm_ff <= PWM_RESET;
      reload_ff <= RELOAD_RESET;
      status_ff <= EVT_NONE;
      mask_ff <= EVT_NONE;
      out_ff <= 1'b0;
      rdata_ff <= BYTE_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
      count_ff <= nxt_count;
      pwm_ff <= nxt_pwm;
      reload_ff <= nxt_reload;
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      out_ff <= nxt_out;
      rdata_ff <= nxt_rdata;
    end
  end

  assign regRdata = rdata_ff;
  assign timerOut = out_ff;
  // Driven (enable low) only when the pin function is selected
  assign timerOutEn = !ctrl_ff.pinEnable;
  // Level output; software clears the cause through the status byte
  assign irq = |(status_ff & mask_ff);

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  pwm_restart_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RL2
    (ctrl_ff.mode == MODE_PWM && reloadHit && !regWrite) |=> (count_ff == 16'h0001 && status_ff[EVT_RELOAD]))
    else $error("pwm reload did not restart count");
  pwm_toggle_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RL1
    (ctrl_ff.mode == MODE_PWM && matchHit && !reloadHit && !regWrite) |=> (out_ff != $past(out_ff)))
    else $error("pwm match did not toggle");
  pwm_level_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RL3
    (ctrl_ff.mode == MODE_PWM && reloadHit && !regWrite) |=> (out_ff == $past(ctrl_ff.polarity)))
    else $error("pwm reload level wrong");
  cap_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RL8
    (ctrl_ff.mode == MODE_CAPTURE && !capEvt && !regWrite) |=> $stable(pwm_ff))
    else $error("capture value changed without capture");
  cap_src_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RL9
    (ctrl_ff.mode == MODE_CAPTURE && ctrl_ff.isrc == ISRC_CAPTURE && !status_ff[EVT_RELOAD] && !regWrite)
    |=> !status_ff[EVT_RELOAD])
    else $error("reload interrupt not suppressed");
  cmp_continue_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RL10
    (ctrl_ff.mode == MODE_COMPARE && reloadHit && !regWrite) |=> (count_ff == $past(count_ff) + 16'h0001))
    else $error("compare reset the count");
  cmp_invert_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RL11
    (ctrl_ff.mode == MODE_COMPARE && reloadHit && ctrl_ff.pinEnable && !regWrite) |=> (out_ff != $past(out_ff)))
    else $error("compare did not invert output");
  cmp_wrap_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RL12
    (ctrl_ff.mode == MODE_COMPARE && tick && count_ff == 16'hffff && !regWrite) |=> (count_ff == 16'h0000))
    else $error("compare did not wrap");
  hold_off_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RL13
    (!ctrl_ff.enable && !regWrite) |=> $stable(count_ff))
    else $error("count moved while disabled");

  // ---------------------------------------------------------------------------
  // Counter, capture and output checks
  // ---------------------------------------------------------------------------
  cap_load_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RL8
    (capEvt && !regWrite) |=> (pwm_ff == $past(count_ff)))
    else $error("capture did not store the count");
  cap_flag_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RL9
    (capEvt && ctrl_ff.isrc != ISRC_RELOAD) |=> status_ff[EVT_CAPTURE])
    else $error("capture event not flagged");
  cap_only_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RL9
    (ctrl_ff.mode == MODE_CAPTURE && ctrl_ff.isrc == ISRC_RELOAD && !status_ff[EVT_CAPTURE] && !regWrite)
    |=> !status_ff[EVT_CAPTURE])
    else $error("capture interrupt not suppressed");
  cap_restart_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ctrl_ff.mode == MODE_CAPTURE && reloadHit && !regWrite) |=> (count_ff == 16'h0001))
    else $error("capture reload did not restart count");
  pwm_step_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RL1
    (ctrl_ff.mode == MODE_PWM && tick && count_ff != reload_ff && !regWrite)
    |=> (count_ff == $past(count_ff) + 16'h0001))
    else $error("pwm count did not step");
  cmp_steady_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RL11
    (ctrl_ff.mode == MODE_COMPARE && !reloadHit && !regWrite) |=> $stable(out_ff))
    else $error("compare output moved without compare");
  tick_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RL13
    (ctrl_ff.enable && !tick && !regWrite) |=> $stable(count_ff))
    else $error("count moved between ticks");

  // ---------------------------------------------------------------------------
  // Status, read port and output checks
  // ---------------------------------------------------------------------------
  reload_flag_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RL2
    evt.reload |=> status_ff[EVT_RELOAD])
    else $error("reload event lost");
  pwm_flag_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RL1
    (ctrl_ff.mode == MODE_PWM && matchHit && !reloadHit) |=> status_ff[EVT_MATCH])
    else $error("pwm match not flagged");
  cmp_flag_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RL10
    (ctrl_ff.mode == MODE_COMPARE && reloadHit) |=> status_ff[EVT_RELOAD])
    else $error("compare event not flagged");
  status_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (regWrite && regAddr == ISTAT_OFS && !evt.reload && !evt.match && !evt.capture)
    |=> (status_ff == ($past(status_ff) & ~$past(regWdata[2:0]))))
    else $error("status write-one clear wrong");
  read_idle_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !regRead |=> (regRdata == 8'h00))
    else $error("read data not zero when idle");
  pin_idle_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!ctrl_ff.enable && !regWrite) |=> $stable(out_ff))
    else $error("output moved while disabled");

endmodule : timer_pwm_capture_compare

// *** verif/timer_pin_model.sv ***
// Model of the board circuit on the timer pin: pull-up plus a capture pulser.
// Assumes the bench drives sys_clk and calls pulse() from its own thread.
`timescale 1ns/10ps
module timer_pin_model (
  input wire logic sys_clk,
  input wire logic timerOut,
  input wire logic timerOutEn,
  output logic captureIn,
  output logic pinLevel
);
  // Pull-up wins whenever the timer is not driving (enable is active low)
  assign pinLevel = timerOutEn ? 1'b1 : timerOut;

  initial begin
    captureIn = 1'b0;
  end

  // Held several cycles so the two-stage synchroniser cannot miss it
  task automatic pulse();
    @(posedge sys_clk);
    captureIn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    captureIn <= 1'b0;
  endtask : pulse
endmodule : timer_pin_model

// *** verif/test_timer_pwm_capture_compare.sv ***
// Self-checking bench for the 16-bit timer through its byte register port.
// Assumes the register map of timer_pkg and one-cycle read latency.
`timescale 1ns/10ps
module test_timer_pwm_capture_compare;
  import timer_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regRdata;
  logic captureIn, timerOut, timerOutEn, irq, pinLevel;
  int nFail = 0;
  int totalChecks = 0;
  int cycles = 0;
  int n;
  logic [15:0] v;

  timer_pwm_capture_compare timer_pwm_capture_compare_i (.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .captureIn(captureIn),
    .timerOut(timerOut), .timerOutEn(timerOutEn), .irq(irq));
  timer_pin_model timer_pin_model_i (.sys_clk(sys_clk), .timerOut(timerOut), .timerOutEn(timerOutEn),
    .captureIn(captureIn), .pinLevel(pinLevel));

  always #5 sys_clk = ~sys_clk;

  // ---------------------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------------------
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      nFail++;
      stop_test();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // ---------------------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask : rd

  task automatic wr16(input logic [3:0] a, input logic [15:0] d);
    wr(a, d[15:8]);
    wr(a + 4'h1, d[7:0]);
  endtask : wr16

  task automatic rd16(input logic [3:0] a, output logic [15:0] d);
    rd(a, d[15:8]);
    rd(a + 4'h1, d[7:0]);
  endtask : rd16

  // Cycles until the pin reaches a level; 200 means it never did
  task automatic gap(input logic lvl, output int cnt);
    cnt = 0;
    while (pinLevel !== lvl && cnt < 200) begin
      @(negedge sys_clk);
      cnt++;
    end
  endtask : gap

  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    rd16(CNTH_OFS, v); chk("countReset", 16'h0001, v);
    rd16(PWMH_OFS, v); chk("pwmReset", 16'h0000, v);
    rd16(RLDH_OFS, v); chk("reloadReset", 16'hffff, v);
    rd(CTL1_OFS, v[7:0]); chk("ctl1Reset", 16'h0000, {8'h00, v[7:0]});
    rd(4'ha, v[7:0]); chk("unmapped", 16'h0000, {8'h00, v[7:0]});
    // PWM, high polarity, every cycle
    wr(CTL1_OFS, 8'h40);
    wr16(CNTH_OFS, 16'h0001);
    wr16(PWMH_OFS, 16'h0002);
    wr16(RLDH_OFS, 16'h0007);
    wr(IMASK_OFS, 8'h01);
    wr(CTL0_OFS, 8'h04);
    #1 chk("pwmStartHigh", 16'h0001, {15'h0, pinLevel});
    wr(CTL1_OFS, 8'hc0);
    gap(1'b0, n);
    gap(1'b1, n); chk("lowWidth", 16'd5, n[15:0]);
    gap(1'b0, n); chk("highWidth", 16'd2, n[15:0]);
    chk("irqReload", 16'h0001, {15'h0, irq});
    wr(IMASK_OFS, 8'h00);
    #1 chk("irqMasked", 16'h0000, {15'h0, irq});
    // Low polarity, divide by two, odd start count
    wr(CTL1_OFS, 8'h08);
    #1 chk("pwmStartLow", 16'h0000, {15'h0, pinLevel});
    wr(ISTAT_OFS, 8'h07);
    rd(ISTAT_OFS, v[7:0]); chk("statusCleared", 16'h0000, {8'h00, v[7:0]});
    wr16(CNTH_OFS, 16'h0005);
    repeat (10) @(posedge sys_clk);
    rd16(CNTH_OFS, v); chk("countHeld", 16'h0005, v);
    wr(CTL1_OFS, 8'h88);
    gap(1'b1, n); chk("firstHighDiv", 16'd11, n[15:0]);
    gap(1'b0, n); chk("highWidthDiv", 16'd10, n[15:0]);
    gap(1'b1, n); chk("lowWidthDiv", 16'd4, n[15:0]);
    // Capture, reload-only interrupt source
    wr(CTL1_OFS, 8'h01);
    wr16(PWMH_OFS, 16'h0000);
    wr16(RLDH_OFS, 16'h0010);
    wr16(CNTH_OFS, 16'h0001);
    wr(CTL0_OFS, 8'h02);
    wr(ISTAT_OFS, 8'h07);
    wr(CTL1_OFS, 8'h81);
    repeat (60) @(posedge sys_clk);
    wr(CTL1_OFS, 8'h01);
    rd(ISTAT_OFS, v[7:0]); chk("statusReloadOnly", 16'h0001, {8'h00, v[7:0]});
    rd16(PWMH_OFS, v); chk("pwmKeptOnReload", 16'h0000, v);
    // Capture, capture-only interrupt source
    wr(CTL0_OFS, 8'h01);
    wr(ISTAT_OFS, 8'h07);
    wr(IMASK_OFS, 8'h07);
    wr(CTL1_OFS, 8'h81);
    timer_pin_model_i.pulse();
    repeat (10) @(posedge sys_clk);
    wr(CTL1_OFS, 8'h01);
    rd(ISTAT_OFS, v[7:0]); chk("statusCaptureOnly", 16'h0004, {8'h00, v[7:0]});
    chk("irqCapture", 16'h0001, {15'h0, irq});
    rd16(PWMH_OFS, v); chk("pwmCaptured", 16'h0001, {15'h0, v != 16'h0000});
    // Compare across the top of the count
    wr(IMASK_OFS, 8'h00);
    wr(CTL1_OFS, 8'h02);
    wr16(RLDH_OFS, 16'h0004);
    wr16(CNTH_OFS, 16'hfffe);
    wr(ISTAT_OFS, 8'h07);
    wr(CTL0_OFS, 8'h04);
    wr(CTL1_OFS, 8'h82);
    gap(1'b1, n); chk("compareToggle", 16'h0001, {15'h0, n < 20});
    repeat (20) @(posedge sys_clk);
    wr(CTL1_OFS, 8'h02);
    rd16(CNTH_OFS, v);
    chk("countWrapped", 16'h0000, {8'h00, v[15:8]});
    chk("countNoRestart", 16'h0001, {15'h0, v > 16'h0010});
    rd(ISTAT_OFS, v[7:0]); chk("compareEvent", 16'h0001, {15'h0, v[0]});
    stop_test();
  end
endmodule : test_timer_pwm_capture_compare
